// *** rtl/swdt_pkg.sv ***
// Purpose: constants for the system watchdog timer
// Assumes: 10 MHz system clock
// Notes: time-out value is loaded by a firmware service routine through plain ports
package swdt_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int STEP_MS_SEC = 1000;
    localparam int STEP_MS_MIN = 60_000;
    // cycles in one count step for each unit
    localparam longint STEP_CYC_SEC = longint'(CLK_HZ) * STEP_MS_SEC / 1000;
    localparam longint STEP_CYC_MIN = longint'(CLK_HZ) * STEP_MS_MIN / 1000;
    localparam int RST_PULSE_NS = 1000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic ACT_RESET = 1'b0;
    localparam logic ACT_NMI = 1'b1;
    localparam logic UNIT_SEC = 1'b0;
    localparam logic UNIT_MIN = 1'b1;
    typedef enum logic [2:0] {
        SWDT_IDLE = 3'b001,
        SWDT_RUN = 3'b010,
        SWDT_FIRE = 3'b100
    } swdt_state_t;
endpackage

// *** rtl/swdt_top.sv ***
// Purpose: single-count system watchdog timer
// Assumes: load strobe and value come from logic on clk; unit and action straps are pins, synchronised here
// Notes: expiry action is a pulse on either the cold-reset or the nmi output
`timescale 1ns/1ps
module swdt_top
    import swdt_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter longint STEP_SEC = STEP_CYC_SEC,
    parameter longint STEP_MIN = STEP_CYC_MIN,
    parameter int PULSE_CYC = RST_PULSE_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // time-out load
    input wire logic load_stb,
    input wire logic [CNT_W-1:0] load_val,
    // setup options
    input wire logic unit_sel,
    input wire logic action_sel,
    // state and actions
    output logic running,
    output logic [CNT_W-1:0] count,
    output logic cold_rst,
    output logic nmi
);
    localparam int PRE_W = 32;
    // refuse parameters that the 32-bit prescaler or the counter cannot serve
    if (CNT_W < 1 || PULSE_CYC < 1 || STEP_SEC < 1 || STEP_MIN < 1 ||
        STEP_SEC >= 64'h1_0000_0000 || STEP_MIN >= 64'h1_0000_0000)
    begin : g_param_check
        $error("swdt_top: unsupported parameter values");
    end

    swdt_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [PRE_W-1:0] pulse_q, pulse_d;
    logic cold_q, cold_d, nmi_q, nmi_d;
    logic run_q;

    // setup straps come from pins: two flops before any logic reads them
    logic [1:0] strap_meta_q;
    logic [1:0] strap_sync_q;
    wire unit_s = strap_sync_q[0];
    wire action_s = strap_sync_q[1];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end
        else if (clk_en)
        begin
            strap_meta_q <= {action_sel, unit_sel};
            strap_sync_q <= strap_meta_q;
        end
    end

    // prescaler counts the clock cycles of one count step
    wire [PRE_W-1:0] step_last = (unit_s == UNIT_MIN) ? PRE_W'(STEP_MIN - 1) : PRE_W'(STEP_SEC - 1);
    wire step_end = (pre_q == step_last);
    wire load_nz = load_stb && (load_val != '0);
    wire load_zero = load_stb && (load_val == '0);
    // a load in the expiry cycle wins: the refresh arrived in time
    wire expire = (state_q == SWDT_RUN) && step_end && (cnt_q == CNT_W'(1)) && !load_stb;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        pre_d = pre_q;
        pulse_d = pulse_q;
        cold_d = cold_q;
        nmi_d = nmi_q;
        case (state_q)
            SWDT_IDLE:
            begin
                if (load_nz)
                begin
                    state_d = SWDT_RUN;
                    cnt_d = load_val;
                    pre_d = '0;
                end
            end
            SWDT_RUN:
            begin
                if (load_zero)
                begin
                    state_d = SWDT_IDLE;
                    cnt_d = '0;
                    pre_d = '0;
                end
                else if (load_nz)
                begin
                    cnt_d = load_val;
                    pre_d = '0;
                end
                else if (expire)
                begin
                    state_d = SWDT_FIRE;
                    cnt_d = '0;
                    pre_d = '0;
                    pulse_d = '0;
                    cold_d = (action_s == ACT_RESET);
                    nmi_d = (action_s == ACT_NMI);
                end
                else if (step_end)
                begin
                    cnt_d = cnt_q - CNT_W'(1);
                    pre_d = '0;
                end
                else
                begin
                    pre_d = pre_q + PRE_W'(1);
                end
            end
            SWDT_FIRE:
            begin
                if (pulse_q == PRE_W'(PULSE_CYC - 1))
                begin
                    state_d = SWDT_IDLE;
                    cold_d = 1'b0;
                    nmi_d = 1'b0;
                end
                else
                begin
                    pulse_d = pulse_q + PRE_W'(1);
                end
            end
            default:
            begin
                state_d = SWDT_IDLE;
                cold_d = 1'b0;
                nmi_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= SWDT_IDLE;
            cnt_q <= '0;
            pre_q <= '0;
            pulse_q <= '0;
            cold_q <= 1'b0;
            nmi_q <= 1'b0;
            run_q <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pre_q <= pre_d;
            pulse_q <= pulse_d;
            cold_q <= cold_d;
            nmi_q <= nmi_d;
            run_q <= (state_d == SWDT_RUN);
        end
    end

    always_comb running = run_q;
    always_comb count = cnt_q;
    always_comb cold_rst = cold_q;
    always_comb nmi = nmi_q;

    sequence s_fire_start;
        clk_en && expire;
    endsequence
    sequence s_pulse_done;
        clk_en && state_q == SWDT_FIRE && pulse_q == PRE_W'(PULSE_CYC - 1);
    endsequence
    sequence s_load_run;
        clk_en && running && load_nz;
    endsequence

    a_start_count: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && load_nz && state_q != SWDT_FIRE |=> running && count == $past(load_val))
        else $error("nonzero load did not start count");
    a_reload_count: assert property (@(posedge clk) disable iff (!arst_n)
        s_load_run |=> count == $past(load_val) && pre_q == '0)
        else $error("reload did not refresh count");
    a_reload_wins: assert property (@(posedge clk) disable iff (!arst_n)
        s_load_run |=> running && !cold_rst && !nmi)
        else $error("reload did not prevent expiry");
    a_count_nonzero: assert property (@(posedge clk) disable iff (!arst_n)
        running |-> count != '0)
        else $error("running watchdog holds zero count");
    a_zero_disable: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && load_zero && state_q != SWDT_FIRE |=> !running && !cold_rst && !nmi)
        else $error("zero load did not disable");
    a_expire_reset: assert property (@(posedge clk) disable iff (!arst_n)
        (s_fire_start and action_s == ACT_RESET) |=> cold_rst && !nmi)
        else $error("expiry gave no cold reset");
    a_one_action: assert property (@(posedge clk) disable iff (!arst_n)
        !(cold_rst && nmi))
        else $error("both expiry actions active");
    a_expire_nmi: assert property (@(posedge clk) disable iff (!arst_n)
        (s_fire_start and action_s == ACT_NMI) |=> nmi && !cold_rst)
        else $error("expiry gave no nmi");
    a_fire_hold: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == SWDT_FIRE |-> cold_rst || nmi)
        else $error("expiry action dropped early");
    a_fire_end: assert property (@(posedge clk) disable iff (!arst_n)
        s_pulse_done |=> state_q == SWDT_IDLE && !cold_rst && !nmi)
        else $error("expiry action did not end");
    a_refuse_fire: assert property (@(posedge clk) disable iff (!arst_n)
        clk_en && state_q == SWDT_FIRE && load_stb |=> !running)
        else $error("load taken during expiry action");
    a_freeze: assert property (@(posedge clk) disable iff (!arst_n)
        !clk_en |=> $stable(state_q) && $stable(cnt_q) && $stable(pre_q) && $stable(pulse_q))
        else $error("state moved while clock enable low");
    a_step_unit: assert property (@(posedge clk) disable iff (!arst_n)
        running && $changed(count) && !$past(load_stb) |-> $past(pre_q) == $past(step_last))
        else $error("count stepped off unit boundary");
    a_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        state_q == SWDT_IDLE |-> !cold_rst && !nmi && count == '0)
        else $error("idle watchdog not quiet");
endmodule

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the system watchdog timer
// Assumes: shortened steps of 4 and 6 cycles, a 2-cycle action pulse
// Notes: inputs change on the falling edge; clk_en drops only in the freeze scenario
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module tb;
    import swdt_pkg::*;
    logic clk, arst_n, clk_en, load_stb, unit_sel, action_sel;
    logic [7:0] load_val;
    logic running, cold_rst, nmi;
    logic [7:0] count;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    swdt_top #(.STEP_SEC(4), .STEP_MIN(6), .PULSE_CYC(2)) swdt_top_i (.clk(clk), .arst_n(arst_n),
        .clk_en(clk_en), .load_stb(load_stb), .load_val(load_val), .unit_sel(unit_sel),
        .action_sel(action_sel), .running(running), .count(count), .cold_rst(cold_rst), .nmi(nmi));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task conclude();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // guard against a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            fail_count++;
            conclude();
        end
    end
    task load(input logic [7:0] v);
        load_stb = 1'b1;
        load_val = v;
        @(negedge clk);
        load_stb = 1'b0;
    endtask
    task t_expire(input logic u, input logic a, input logic [7:0] n);
        int step;
        step = u ? 6 : 4;
        unit_sel = u;
        action_sel = a;
        load(n);
        `CHK("count", n, count)
        `CHK("running", 1'b1, running)
        repeat (step) @(negedge clk);
        `CHK("count", n - 8'h01, count)
        repeat (n * step - step - 1) @(negedge clk);
        `CHK("action", 2'b00, {cold_rst, nmi})
        @(negedge clk);
        `CHK("action", (a ? 2'b01 : 2'b10), {cold_rst, nmi})
        `CHK("running", 1'b0, running)
        repeat (2) @(negedge clk);
        `CHK("action", 2'b00, {cold_rst, nmi})
    endtask
    task t_reload_disable();
        unit_sel = 1'b0;
        action_sel = 1'b0;
        load(8'h03);
        repeat (8) @(negedge clk);
        `CHK("count", 8'h01, count)
        load(8'h03);
        `CHK("count", 8'h03, count)
        repeat (10) @(negedge clk);
        `CHK("count", 8'h01, count)
        `CHK("action", 2'b00, {cold_rst, nmi})
        load(8'h00);
        `CHK("running", 1'b0, running)
        `CHK("count", 8'h00, count)
        repeat (20) @(negedge clk);
        `CHK("action", 2'b00, {cold_rst, nmi})
    endtask
    task t_power_up();
        repeat (10) @(negedge clk);
        `CHK("idle state", 11'h000, {running, count, cold_rst, nmi})
    endtask
    task t_freeze();
        unit_sel = UNIT_SEC;
        action_sel = ACT_RESET;
        load(8'h02);
        clk_en = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("frozen count", 9'h102, {running, count})
        clk_en = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("count", 8'h01, count)
        load(8'h00);
        `CHK("running", 1'b0, running)
    endtask
    task t_mid_reset();
        unit_sel = UNIT_SEC;
        action_sel = ACT_RESET;
        load(8'h03);
        repeat (5) @(negedge clk);
        `CHK("count", 8'h02, count)
        arst_n = 1'b0;
        @(negedge clk);
        `CHK("reset state", 11'h000, {running, count, cold_rst, nmi})
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        `CHK("idle state", 11'h000, {running, count, cold_rst, nmi})
        repeat (20) @(negedge clk);
        `CHK("action", 2'b00, {cold_rst, nmi})
    endtask
    initial
    begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        load_stb = 1'b0;
        load_val = 8'h00;
        unit_sel = 1'b0;
        action_sel = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_power_up();
        t_expire(1'b0, ACT_RESET, 8'h03);
        t_expire(1'b1, ACT_NMI, 8'h02);
        t_freeze();
        t_mid_reset();
        t_reload_disable();
        conclude();
    end
endmodule
